/* rtl/bisr_cfg.svh */
// constants for the pack identity and status responder
`ifndef BISR_CFG_SVH
`define BISR_CFG_SVH
// command codes
`define BISR_CMD_DATE 8'h1B
`define BISR_CMD_SERIAL 8'h1C
`define BISR_CMD_MAKER 8'h20
`define BISR_CMD_MODEL 8'h21
`define BISR_CMD_CTYPE 8'h22
`define BISR_CMD_SNAP 8'h23
`define BISR_CMD_STAT 8'h2F
`define BISR_CMD_CELL_LO 8'h3C
`define BISR_CMD_CELL_HI 8'h3F
// configuration flash locations, high byte at the lower address
`define BISR_DF_FIRST 8'h08
`define BISR_DF_LAST 8'h31
`define BISR_SHADOW_N 8'h2A
`define BISR_DF_DATE 8'h08
`define BISR_DF_SERIAL 8'h0A
`define BISR_DF_HIST 8'h0C
`define BISR_DF_MAKER 8'h0E
`define BISR_DF_MODEL 8'h1A
`define BISR_DF_CTYPE 8'h22
`define BISR_DF_PACKCFG 8'h28
`define BISR_DF_GAUGE 8'h29
`define BISR_DF_MISC 8'h2A
`define BISR_DF_DEADBAND 8'h2C
`define BISR_DF_SDR 8'h2D
`define BISR_DF_LOAD 8'h2E
`define BISR_DF_BLOW 8'h2F
`define BISR_DF_NEARFULL 8'h30
// text and snapshot lengths
`define BISR_MAX_MAKER 8'h0B
`define BISR_MAX_MODEL 8'h07
`define BISR_MAX_CTYPE 8'h04
`define BISR_SNAP_LEN 8'h0D
// failure marker values
`define BISR_PF_SET 8'h66
`define BISR_PF_CLR 8'h00
// build date field positions
`define BISR_DAY_LSB 0
`define BISR_MONTH_LSB 5
`define BISR_YEAR_LSB 9
// pack status bit positions
`define BISR_ST_INSERTED 7
`define BISR_ST_EDV 6
`define BISR_ST_SEALED 5
`define BISR_ST_DQ 4
`define BISR_ST_AFE 3
`define BISR_ST_PF 2
`define BISR_ST_OVER 1
`define BISR_ST_UNDER 0
// gauge configuration bit: 1 compares lowest cell, 0 the pack
`define BISR_EDV_SRC_BIT 3
// bus address and filler for bytes past the end
`define BISR_SMB_ADDR 7'h0B
`define BISR_FILL 8'hFF
`define BISR_BIT_LAST 4'h8
`endif

/* rtl/bisr_pkg.sv */
// types for the pack identity and status responder
package bisr_pkg;
  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_RX, L_ACK, L_TX, L_MACK, L_LOAD} bisr_link_state_type;
  typedef enum logic [1:0] {M_LOAD, M_RUN, M_HIST_HI, M_HIST_LO} bisr_main_state_type;
  // events from the bus engine, all one-cycle pulses
  typedef struct packed {
    logic start;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic tx_next;
  } bisr_link_ev_type;
  // live gauge state from the same clock domain
  typedef struct packed {
    logic sealed;
    logic dis_qual;
    logic afe_fail;
    logic over_fault;
    logic under_fault;
    logic [7:0] fail_marker;
    logic [7:0] afe_status;
    logic [15:0] pack_mv;
    logic [15:0] edv_mv;
  } bisr_gauge_type;
  typedef logic [3:0][15:0] bisr_cell_mv_type;
endpackage : bisr_pkg

/* rtl/bisr_responder.sv */
// pack identity and status responder: flash shadow, status byte, replies
`timescale 1ns/1ps
`default_nettype none
`include "bisr_cfg.svh"
// How it works
// - read-word 0x1b returns build date word from flash bytes 0x08-0x09.
// - date word: day bits 0-4, month bits 5-8, year-1980 bits 9-15.
// - read-word 0x1c returns pack serial word from flash bytes 0x0a-0x0b.
// - read-block 0x20 returns maker text, length byte then up to 11 characters.
// - read-block 0x21 returns pack model text, length then up to 7 characters.
// - read-block 0x22 returns cell type text, length then up to 4 characters.
// - cell type text never steers charge control or gauging.
// - read-block 0x23 returns configuration snapshot, length then 13 bytes.
// - snapshot order: pack, gauge, misc(2), band, discharge, load, low, near-full(2), afe, edv.
// - read-word 0x2f: status byte low, pack configuration byte 0x28 high.
// - status bits b7..b0: inserted, edv-low, sealed, qualified, afe-fail, fail, over, under.
// - inserted bit is 1 while the pack sits in a system.
// - edv-low bit is 1 when chosen voltage is at or below the threshold.
// - sealed bit is 1 in the sealed security state.
// - front-end link fail bit is 1 while front-end communication has failed.
// - discharge-qualified bit is 1 when this discharge qualifies for update.
// - fail bit sets on marker 0x66, clears only on marker 0x00.
// - over-limit bit follows present secondary protection state, unlatched.
// - under-limit bit follows present overload or overdischarge state, unlatched.
// - commands 0x3c-0x3f return one cell voltage each in millivolts.
// - flash is read after reset and written only to store history.
module bisr_responder (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [7:0] df_addr_o,
  input wire logic [7:0] df_rdata_i,
  output logic [7:0] df_wdata_o,
  output logic df_we_o,
  input wire logic hist_store_i,
  input wire logic [15:0] hist_word_i,
  input wire logic inserted_i,
  input wire bisr_pkg::bisr_gauge_type gauge_i,
  input wire bisr_pkg::bisr_cell_mv_type cells_i,
  output logic cfg_ready_o,
  output logic [7:0] pack_status_o
);
  bisr_pkg::bisr_main_state_type state_q;
  bisr_pkg::bisr_link_ev_type ev;
  logic [7:0] shadow_q [0:41];
  logic [7:0] ld_ptr_q;
  logic [7:0] cap_addr_q;
  logic cap_q;
  logic ready_q;
  logic [7:0] df_addr_q, df_wdata_q;
  logic df_we_q;
  logic [15:0] hist_q;
  logic ins_m_q, ins_s_q;
  logic pf_q;
  logic [7:0] status_q;
  logic [7:0] cmd_q;
  logic got_cmd_q;
  logic [7:0] idx_q;
  logic [15:0] word_q;
  logic sda_lo_q;
  logic link_oe;
  logic [7:0] tx_byte;
  logic [15:0] edv_src_mv, cell_min_mv, lo_pair_mv, hi_pair_mv, word_d;
  logic edv_low;
  logic [7:0] cap_off;
  logic [7:0] gauge_cfg;

  // shadow byte at a flash address; outside the shadow reads as filler
  function automatic logic [7:0] df_byte(input logic [7:0] a);
    logic [7:0] off;
    off = a - `BISR_DF_FIRST;
    df_byte = (off < `BISR_SHADOW_N) ? shadow_q[off[5:0]] : `BISR_FILL;
  endfunction : df_byte

  // stored word, high byte held at the lower address
  function automatic logic [15:0] df_word(input logic [7:0] a);
    df_word = {df_byte(a), df_byte(a + 8'h01)};
  endfunction : df_word

  // text reply: clamped length byte, then characters, then filler
  function automatic logic [7:0] text_byte(input logic [7:0] base, input logic [7:0] max,
                                           input logic [7:0] idx);
    logic [7:0] len;
    len = (df_byte(base) > max) ? max : df_byte(base);
    if (idx == 8'h00)
      text_byte = len;
    else if (idx <= len)
      text_byte = df_byte(base + idx);
    else
      text_byte = `BISR_FILL;
  endfunction : text_byte

  // snapshot reply in its fixed order
  function automatic logic [7:0] snap_byte(input logic [7:0] idx, input logic [15:0] edv,
                                           input logic [7:0] afe);
    case (idx)
      8'h00: snap_byte = `BISR_SNAP_LEN;
      8'h01: snap_byte = df_byte(`BISR_DF_PACKCFG);
      8'h02: snap_byte = df_byte(`BISR_DF_GAUGE);
      8'h03: snap_byte = df_byte(`BISR_DF_MISC);
      8'h04: snap_byte = df_byte(`BISR_DF_MISC + 8'h01);
      8'h05: snap_byte = df_byte(`BISR_DF_DEADBAND);
      8'h06: snap_byte = df_byte(`BISR_DF_SDR);
      8'h07: snap_byte = df_byte(`BISR_DF_LOAD);
      8'h08: snap_byte = df_byte(`BISR_DF_BLOW);
      8'h09: snap_byte = df_byte(`BISR_DF_NEARFULL);
      8'h0A: snap_byte = df_byte(`BISR_DF_NEARFULL + 8'h01);
      8'h0B: snap_byte = afe;
      8'h0C: snap_byte = edv[7:0];
      8'h0D: snap_byte = edv[15:8];
      default: snap_byte = `BISR_FILL;
    endcase
  endfunction : snap_byte

  // flash load after reset, then history writes only
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      state_q <= bisr_pkg::M_LOAD;
      ld_ptr_q <= `BISR_DF_FIRST;
      cap_q <= 1'b0;
      cap_addr_q <= 8'h00;
      df_addr_q <= 8'h00;
      df_wdata_q <= 8'h00;
      df_we_q <= 1'b0;
      hist_q <= 16'h0000;
      ready_q <= 1'b0;
    end
    else
    begin
      cap_q <= 1'b0;
      df_we_q <= 1'b0;
      ready_q <= (state_q != bisr_pkg::M_LOAD) && !cap_q;
      case (state_q)
        bisr_pkg::M_LOAD:
        begin
          df_addr_q <= ld_ptr_q;
          cap_addr_q <= ld_ptr_q;
          cap_q <= 1'b1;
          ld_ptr_q <= ld_ptr_q + 8'h01;
          if (ld_ptr_q == `BISR_DF_LAST)
            state_q <= bisr_pkg::M_RUN;
        end
        bisr_pkg::M_RUN:
        begin
          if (hist_store_i)
          begin
            hist_q <= hist_word_i;
            state_q <= bisr_pkg::M_HIST_HI;
          end
        end
        bisr_pkg::M_HIST_HI:
        begin
          df_addr_q <= `BISR_DF_HIST;
          df_wdata_q <= hist_q[15:8];
          df_we_q <= 1'b1;
          state_q <= bisr_pkg::M_HIST_LO;
        end
        bisr_pkg::M_HIST_LO:
        begin
          df_addr_q <= `BISR_DF_HIST + 8'h01;
          df_wdata_q <= hist_q[7:0];
          df_we_q <= 1'b1;
          state_q <= bisr_pkg::M_RUN;
        end
        default: state_q <= bisr_pkg::M_LOAD;
      endcase
    end
  end

  // flash answers one cycle after the address
  assign cap_off = cap_addr_q - `BISR_DF_FIRST;
  always_ff @(posedge clk_sys_i)
  begin
    if (cap_q)
      shadow_q[cap_off[5:0]] <= df_rdata_i;
  end

  // voltage source chosen by the gauge configuration option
  assign lo_pair_mv = (cells_i[0] < cells_i[1]) ? cells_i[0] : cells_i[1];
  assign hi_pair_mv = (cells_i[2] < cells_i[3]) ? cells_i[2] : cells_i[3];
  assign cell_min_mv = (lo_pair_mv < hi_pair_mv) ? lo_pair_mv : hi_pair_mv;
  assign gauge_cfg = shadow_q[6'(`BISR_DF_GAUGE - `BISR_DF_FIRST)]; // direct read, so it follows the load
  assign edv_src_mv = gauge_cfg[`BISR_EDV_SRC_BIT] ? cell_min_mv : gauge_i.pack_mv;
  assign edv_low = (edv_src_mv <= gauge_i.edv_mv);

  // inserted comes from a pin, so it is synchronised first
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      ins_m_q <= 1'b0;
      ins_s_q <= 1'b0;
    end
    else
    begin
      ins_m_q <= inserted_i;
      ins_s_q <= ins_m_q;
    end
  end

  // fail bit holds on any marker value other than the two known ones
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      pf_q <= 1'b0;
    else if (gauge_i.fail_marker == `BISR_PF_SET)
      pf_q <= 1'b1;
    else if (gauge_i.fail_marker == `BISR_PF_CLR)
      pf_q <= 1'b0;
  end

  // status byte refreshed every cycle; over and under fault bits are never latched
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      status_q <= 8'h00;
    else
    begin
      status_q[`BISR_ST_INSERTED] <= ins_s_q;
      status_q[`BISR_ST_EDV] <= edv_low;
      status_q[`BISR_ST_SEALED] <= gauge_i.sealed;
      status_q[`BISR_ST_DQ] <= gauge_i.dis_qual;
      status_q[`BISR_ST_AFE] <= gauge_i.afe_fail;
      status_q[`BISR_ST_PF] <= pf_q;
      status_q[`BISR_ST_OVER] <= gauge_i.over_fault;
      status_q[`BISR_ST_UNDER] <= gauge_i.under_fault;
    end
  end

  // word replies; date word passes with its day/month/year layout intact
  assign word_d =
    (ev.rx_byte == `BISR_CMD_DATE) ? df_word(`BISR_DF_DATE) :
    (ev.rx_byte == `BISR_CMD_SERIAL) ? df_word(`BISR_DF_SERIAL) :
    (ev.rx_byte == `BISR_CMD_STAT) ? {df_byte(`BISR_DF_PACKCFG), status_q} :
    (ev.rx_byte == `BISR_CMD_CELL_LO) ? cells_i[3] :
    (ev.rx_byte == `BISR_CMD_CELL_LO + 8'h01) ? cells_i[2] :
    (ev.rx_byte == `BISR_CMD_CELL_LO + 8'h02) ? cells_i[1] :
    (ev.rx_byte == `BISR_CMD_CELL_HI) ? cells_i[0] :
    (ev.rx_byte == `BISR_CMD_SNAP) ? gauge_i.edv_mv :
    {`BISR_FILL, `BISR_FILL};

  // command and byte index; the word is frozen so its halves never tear
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      cmd_q <= 8'h00;
      got_cmd_q <= 1'b0;
      idx_q <= 8'h00;
      word_q <= 16'h0000;
    end
    else if (ev.start)
    begin
      got_cmd_q <= 1'b0;
      idx_q <= 8'h00;
    end
    else if (ev.rx_valid && !got_cmd_q)
    begin
      cmd_q <= ev.rx_byte;
      got_cmd_q <= 1'b1;
      idx_q <= 8'h00;
      word_q <= word_d;
    end
    else if (ev.tx_next && idx_q != 8'hFF)
      idx_q <= idx_q + 8'h01;
  end

  // byte to send; text bytes only ever reach the bus
  assign tx_byte =
    (cmd_q == `BISR_CMD_MAKER) ? text_byte(`BISR_DF_MAKER, `BISR_MAX_MAKER, idx_q) :
    (cmd_q == `BISR_CMD_MODEL) ? text_byte(`BISR_DF_MODEL, `BISR_MAX_MODEL, idx_q) :
    (cmd_q == `BISR_CMD_CTYPE) ? text_byte(`BISR_DF_CTYPE, `BISR_MAX_CTYPE, idx_q) :
    (cmd_q == `BISR_CMD_SNAP) ? snap_byte(idx_q, word_q, gauge_i.afe_status) :
    (idx_q == 8'h00) ? word_q[7:0] :
    (idx_q == 8'h01) ? word_q[15:8] :
    `BISR_FILL;

  // bus engine answers only once the shadow is filled
  bisr_smb_link u_link (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .en_i(ready_q),
    .tx_byte_i(tx_byte),
    .sda_oe_o(link_oe),
    .ev_o(ev)
  );

  // open-drain data line only ever pulls low
  always_ff @(posedge clk_sys_i)
  begin
    sda_lo_q <= 1'b0;
  end

  assign sda_o = sda_lo_q;
  assign sda_oe_o = link_oe;
  assign df_addr_o = df_addr_q;
  assign df_wdata_o = df_wdata_q;
  assign df_we_o = df_we_q;
  assign cfg_ready_o = ready_q;
  assign pack_status_o = status_q;
endmodule : bisr_responder
`default_nettype wire

/* rtl/bisr_smb_link.sv */
// serial bus slave engine: start/stop, address match, byte shift, acks
`timescale 1ns/1ps
`default_nettype none
`include "bisr_cfg.svh"
module bisr_smb_link (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic en_i,
  input wire logic [7:0] tx_byte_i,
  output logic sda_oe_o,
  output bisr_pkg::bisr_link_ev_type ev_o
);
  bisr_pkg::bisr_link_state_type state_q;
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic rw_q;
  logic oe_q;
  bisr_pkg::bisr_link_ev_type ev_q;
  logic rise, fall, start_c, stop_c, addr_hit;

  // two-stage synchronisers plus one stage for edge finding
  always_ff @(posedge clk_sys_i)
  begin
    scl_m_q <= scl_i;
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= sda_i;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
  end

  // bus conditions seen on the synchronised lines
  assign rise = scl_s_q & ~scl_p_q;
  assign fall = ~scl_s_q & scl_p_q;
  assign start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign addr_hit = en_i && (sh_q[7:1] == `BISR_SMB_ADDR);

  // sda changes only after a seen fall, so never while scl is high
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      state_q <= bisr_pkg::L_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      ev_q <= '0;
    end
    else
    begin
      ev_q <= '0;
      if (start_c)
      begin
        state_q <= bisr_pkg::L_ADDR;
        cnt_q <= 4'h0;
        oe_q <= 1'b0;
        ev_q.start <= 1'b1;
      end
      else if (stop_c)
      begin
        state_q <= bisr_pkg::L_IDLE;
        oe_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          bisr_pkg::L_ADDR, bisr_pkg::L_RX:
          begin
            if (rise)
            begin
              sh_q <= {sh_q[6:0], sda_s_q};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (fall && cnt_q == `BISR_BIT_LAST)
            begin
              cnt_q <= 4'h0;
              if (state_q == bisr_pkg::L_RX)
              begin
                oe_q <= 1'b1;
                state_q <= bisr_pkg::L_ACK;
                ev_q.rx_valid <= 1'b1;
                ev_q.rx_byte <= sh_q;
              end
              else if (addr_hit)
              begin
                oe_q <= 1'b1;
                rw_q <= sh_q[0];
                state_q <= bisr_pkg::L_ACK;
              end
              else
                state_q <= bisr_pkg::L_IDLE;
            end
          end
          bisr_pkg::L_ACK:
          begin
            if (fall && rw_q)
            begin
              sh_q <= tx_byte_i;
              oe_q <= ~tx_byte_i[7];
              ev_q.tx_next <= 1'b1;
              state_q <= bisr_pkg::L_TX;
            end
            else if (fall)
            begin
              oe_q <= 1'b0;
              state_q <= bisr_pkg::L_RX;
            end
          end
          bisr_pkg::L_TX:
          begin
            if (rise)
              cnt_q <= cnt_q + 4'h1;
            else if (fall && cnt_q == `BISR_BIT_LAST)
            begin
              oe_q <= 1'b0;
              state_q <= bisr_pkg::L_MACK;
            end
            else if (fall)
            begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_q <= ~sh_q[6];
            end
          end
          // a nack from the host ends the read
          bisr_pkg::L_MACK:
            if (rise)
              state_q <= sda_s_q ? bisr_pkg::L_IDLE : bisr_pkg::L_LOAD;
          bisr_pkg::L_LOAD:
          begin
            if (fall)
            begin
              sh_q <= tx_byte_i;
              oe_q <= ~tx_byte_i[7];
              ev_q.tx_next <= 1'b1;
              cnt_q <= 4'h0;
              state_q <= bisr_pkg::L_TX;
            end
          end
          default: state_q <= bisr_pkg::L_IDLE;
        endcase
      end
    end
  end

  assign sda_oe_o = oe_q;
  assign ev_o = ev_q;
endmodule : bisr_smb_link
`default_nettype wire

/* test/bisr_checker.sv */
// assertion checker for the pack identity and status responder
`timescale 1ns/1ps
`default_nettype none
module bisr_checker (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic inserted_i,
  input wire bisr_pkg::bisr_gauge_type gauge_i,
  input wire logic hist_store_i,
  input wire logic [15:0] hist_word_i,
  input wire logic df_we_o,
  input wire logic [7:0] df_addr_o,
  input wire logic [7:0] df_wdata_o,
  input wire logic cfg_ready_o,
  input wire logic [7:0] pack_status_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  // status bits follow inputs that held still; margin covers sync and register stages
  property p_inserted;
    $stable(inserted_i) [*5] |=> pack_status_o[7] == $past(inserted_i);
  endproperty
  a_inserted: assert property (p_inserted) else $error("inserted bit wrong");
  property p_sealed;
    $stable(gauge_i.sealed) [*3] |=> pack_status_o[5] == $past(gauge_i.sealed);
  endproperty
  a_sealed: assert property (p_sealed) else $error("sealed bit wrong");
  property p_afe;
    $stable(gauge_i.afe_fail) [*3] |=> pack_status_o[3] == $past(gauge_i.afe_fail);
  endproperty
  a_afe: assert property (p_afe) else $error("front-end fail bit wrong");
  property p_over;
    $stable(gauge_i.over_fault) [*3] |=> pack_status_o[1] == $past(gauge_i.over_fault);
  endproperty
  a_over: assert property (p_over) else $error("over-limit bit wrong");
  property p_under;
    $stable(gauge_i.under_fault) [*3] |=> pack_status_o[0] == $past(gauge_i.under_fault);
  endproperty
  a_under: assert property (p_under) else $error("under-limit bit wrong");
  // fail bit tracks the marker's two defined values
  property p_pf_set;
    (gauge_i.fail_marker == 8'h66) [*3] |=> pack_status_o[2];
  endproperty
  a_pf_set: assert property (p_pf_set) else $error("fail bit not set");
  property p_pf_clr;
    (gauge_i.fail_marker == 8'h00) [*3] |=> !pack_status_o[2];
  endproperty
  a_pf_clr: assert property (p_pf_clr) else $error("fail bit not clear");
  // flash writes only follow a history store, high byte first
  property p_hist_hi;
    df_we_o && !$past(df_we_o) |-> $past(hist_store_i, 2) && df_addr_o == 8'h0C
      && df_wdata_o == $past(hist_word_i[15:8], 2);
  endproperty
  a_hist_hi: assert property (p_hist_hi) else $error("history high write wrong");
  property p_hist_lo;
    df_we_o && $past(df_we_o) |-> df_addr_o == 8'h0D && df_wdata_o == $past(hist_word_i[7:0], 3);
  endproperty
  a_hist_lo: assert property (p_hist_lo) else $error("history low write wrong");
  // the flash load after reset takes a fixed span
  property p_ready;
    $fell(reset_i) |-> (!cfg_ready_o) [*8] ##[30:48] cfg_ready_o;
  endproperty
  a_ready: assert property (p_ready) else $error("flash load span wrong");
endmodule : bisr_checker
bind bisr_responder bisr_checker chk_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .inserted_i(inserted_i),
  .gauge_i(gauge_i), .hist_store_i(hist_store_i), .hist_word_i(hist_word_i), .df_we_o(df_we_o),
  .df_addr_o(df_addr_o), .df_wdata_o(df_wdata_o), .cfg_ready_o(cfg_ready_o), .pack_status_o(pack_status_o));
`default_nettype wire

/* test/bisr_host_model.sv */
// serial bus host model: bit-banged read-word and read-block cycles
`timescale 1ns/1ps
`default_nettype none
`include "bisr_cfg.svh"
module bisr_host_model (
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o
);
  // bus idle: clock high, data released
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick
  // data moves only in clock low; sampled late in clock high, after the slow answer
  task automatic bit_io(input logic b, output logic r);
    sda_low_o <= !b;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    r = sda_i;
    scl_o <= 1'b0;
    tick(2);
  endtask : bit_io
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
  endtask : byte_io
  // start or repeated start; first wait lets the device drop its ack
  task automatic start();
    tick(2);
    sda_low_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
    tick(2);
  endtask : start
  task automatic read(input logic [7:0] cmd, input int n);
    logic [7:0] r;
    logic a;
    start();
    byte_io({`BISR_SMB_ADDR, 1'b0}, r);
    bit_io(1'b1, a);
    byte_io(cmd, r);
    bit_io(1'b1, a);
    start();
    byte_io({`BISR_SMB_ADDR, 1'b1}, r);
    bit_io(1'b1, a);
    for (int i = 0; i < n; i++)
    begin
      byte_io(8'hFF, r);
      rx_byte_o <= r; // raw bytes; letter case is the consumer's business
      rx_valid_o <= 1'b1;
      tick(1);
      rx_valid_o <= 1'b0;
      bit_io(i == n - 1, a);
    end
    sda_low_o <= 1'b1;
    tick(4);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b0;
    tick(8);
  endtask : read
endmodule : bisr_host_model
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the pack identity and status responder
`timescale 1ns/1ps
`default_nettype none
`include "bisr_cfg.svh"
module testbench;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic scl, sda_low, sda_o, sda_oe, df_we, cfg_ready, rx_valid;
  logic hist_store = 1'b0, inserted = 1'b0, pf = 1'b0;
  logic [7:0] df_addr, df_wdata, status, rx_byte, df_rdata;
  logic [15:0] hist_word = 16'h0000;
  bisr_pkg::bisr_gauge_type gauge = '0;
  bisr_pkg::bisr_cell_mv_type cells = '0;
  logic [7:0] df_mem [0:255];
  logic [7:0] exp_q [$];
  string tname = "none";
  int mismatches = 0;
  int num_checks = 0;
  wire sda_w = !(sda_low || (sda_oe && !sda_o)); // open drain with pull-up
  initial
  forever #20 clk_sys_i = ~clk_sys_i;
  bisr_responder dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .df_addr_o(df_addr), .df_rdata_i(df_rdata), .df_wdata_o(df_wdata), .df_we_o(df_we),
    .hist_store_i(hist_store), .hist_word_i(hist_word), .inserted_i(inserted), .gauge_i(gauge),
    .cells_i(cells), .cfg_ready_o(cfg_ready), .pack_status_o(status));
  bisr_host_model host_u (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low),
    .rx_valid_o(rx_valid), .rx_byte_o(rx_byte));
  // flash: read data follows the registered address within the cycle
  always_comb df_rdata = df_mem[df_addr];
  always @(posedge clk_sys_i)
  begin
    if (df_we === 1'b1)
      df_mem[df_addr] <= df_wdata;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // each byte the host reads is matched against the oldest note
  always @(posedge clk_sys_i)
    if (rx_valid === 1'b1)
      if (exp_q.size() > 0)
        check(tname, {8'h00, exp_q.pop_front()}, {8'h00, rx_byte});
      else
        check(tname, 16'hDEAD, {8'h00, rx_byte});
  // words travel low byte first
  task automatic push_w(input logic [15:0] w);
    exp_q.push_back(w[7:0]);
    exp_q.push_back(w[15:8]);
  endtask : push_w
  task automatic run(input string name, input logic [7:0] cmd, input int n);
    tname = name;
    host_u.read(cmd, n);
    check({name, " count"}, 16'h0000, 16'(exp_q.size()));
    exp_q.delete();
    $display("test %s done", name);
  endtask : run
  // length clamps to the field maximum; one read past the end gives filler
  task automatic text(input string name, input logic [7:0] cmd, input int base, input int max);
    int len;
    len = df_mem[base] > max ? max : df_mem[base];
    exp_q.push_back(8'(len));
    for (int i = 1; i <= len; i++)
      exp_q.push_back(df_mem[base + i]);
    exp_q.push_back(`BISR_FILL);
    run(name, cmd, len + 2);
  endtask : text
  // watchdog: a hang ends the run as a failure
  initial
  begin
    repeat (90000) @(posedge clk_sys_i);
    mismatches++;
    test_done();
  end
  initial
  begin
    bisr_pkg::bisr_gauge_type g;
    logic [7:0] mk [6];
    logic ins;
    logic [15:0] w;
    void'($urandom(62123));
    mk = '{8'h66, 8'h55, 8'h00, 8'h55, 8'h66, 8'h00};
    for (int a = 0; a < 256; a++)
      df_mem[a] = 8'($urandom());
    {df_mem[8], df_mem[9]} = {7'($urandom_range(127)), 4'($urandom_range(12, 1)), 5'($urandom_range(31, 1))};
    df_mem[8'h0E] = 8'h0E;
    df_mem[8'h1A] = 8'h05;
    df_mem[8'h22] = 8'h04;
    {df_mem[8'h23], df_mem[8'h24], df_mem[8'h25], df_mem[8'h26]} = "LION";
    df_mem[8'h29][`BISR_EDV_SRC_BIT] = 1'b0; // compare pack voltage
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 200 && cfg_ready !== 1'b1; i++)
      @(posedge clk_sys_i);
    check("flash ready", 16'h0001, {15'h0000, cfg_ready});
    push_w({df_mem[8'h08], df_mem[8'h09]});
    run("date", `BISR_CMD_DATE, 2);
    push_w({df_mem[8'h0A], df_mem[8'h0B]});
    run("serial", `BISR_CMD_SERIAL, 2);
    text("maker", `BISR_CMD_MAKER, 8'h0E, 11);
    text("model", `BISR_CMD_MODEL, 8'h1A, 7);
    text("cell type", `BISR_CMD_CTYPE, 8'h22, 4);
    // status word under random gauge state and a marker sequence that holds both ways
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk_sys_i);
      g = bisr_pkg::bisr_gauge_type'(($bits(g))'({$urandom(), $urandom()}));
      g.fail_marker = mk[k];
      ins = 1'($urandom());
      pf = mk[k] == 8'h66 ? 1'b1 : (mk[k] == 8'h00 ? 1'b0 : pf);
      gauge <= g;
      inserted <= ins;
      cells <= {$urandom(), $urandom()};
      repeat (8) @(posedge clk_sys_i);
      w[7:0] = {ins, g.pack_mv <= g.edv_mv, g.sealed, g.dis_qual, g.afe_fail, pf, g.over_fault, g.under_fault};
      check("status byte", {8'h00, w[7:0]}, {8'h00, status});
      push_w({df_mem[`BISR_DF_PACKCFG], w[7:0]});
      run("status", `BISR_CMD_STAT, 2);
    end
    exp_q.push_back(`BISR_SNAP_LEN);
    for (int a = 8'h28; a <= 8'h31; a++)
      exp_q.push_back(df_mem[a]);
    exp_q.push_back(gauge.afe_status);
    push_w(gauge.edv_mv);
    run("snapshot", `BISR_CMD_SNAP, 14);
    for (int c = 0; c < 4; c++)
    begin
      push_w(cells[3 - c]);
      run("cell voltage", 8'(`BISR_CMD_CELL_LO + c), 2);
    end
    push_w({`BISR_FILL, `BISR_FILL});
    run("unknown", 8'h30, 2);
    // history store lands high byte first at the even address
    @(posedge clk_sys_i);
    w = 16'($urandom());
    hist_word <= w;
    hist_store <= 1'b1;
    @(posedge clk_sys_i);
    hist_store <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    check("history", w, {df_mem[8'h0C], df_mem[8'h0D]});
    $display("test history done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
